// [hdl/startup_timeout_supervisor_regs.svh]
// Command codes, field positions, limits and timing figures of the start-up supervisor
`ifndef STARTUP_TIMEOUT_SUPERVISOR_REGS_SVH
`define STARTUP_TIMEOUT_SUPERVISOR_REGS_SVH

`define CMD_TURN_ON_DELAY 8'h60
`define CMD_SOFT_START_RISE_TIME 8'h61
`define CMD_STARTUP_TIMEOUT_LIMIT 8'h62
`define CMD_STARTUP_TIMEOUT_RESPONSE 8'h63
`define CMD_TURN_OFF_DELAY_TIME 8'h64

`define EXP_MSB 15
`define EXP_LSB 11
`define MAN_MSB 10
`define EXP_QUARTER_MS 5'h1e
`define EXP_HALF_MS 5'h1f

`define ACTION_MSB 7
`define ACTION_LSB 6
`define RETRY_MSB 5
`define RETRY_LSB 3
`define DELAY_MSB 2
`define DELAY_LSB 0
`define ACT_DELAYED 2'h1
`define ACT_SHUTDOWN 2'h2
`define RETRY_LATCH 3'h0
`define RETRY_FOREVER 3'h7

`define RISE_MAX_Q 13'h007f
`define RISE_MIN_Q 13'h0002
`define LIMIT_MAX_Q 13'h01fc
`define ON_DELAY_MAX_Q 13'h01fe
`define OFF_DELAY_MAX_Q 13'h01fe

`define TICK_TIME_NS 50000
`define CLOCK_PERIOD_NS 4
`define SUB_PER_QUARTER 16'h0005
`define SUB_PER_MS 16'h0014

`define GOOD_NUM 8'hd9
`define GOOD_SHIFT 8
`define FAULT_SHIFT 3

`endif

// [hdl/startup_timeout_supervisor_pkg.sv]
// Types shared by the start-up supervisor
package startup_timeout_supervisor_pkg;
    typedef logic [15:0] word_t;
    typedef logic [12:0] quarters_t;
    typedef enum logic [7:0] {
        ST_OFF = 8'h01,
        ST_ON_DELAY = 8'h02,
        ST_RISE = 8'h04,
        ST_REGULATE = 8'h08,
        ST_FAULT_DELAY = 8'h10,
        ST_RESTART_WAIT = 8'h20,
        ST_LATCHED = 8'h40,
        ST_OFF_DELAY = 8'h80
    } seq_state_e;
endpackage

// [hdl/sub_ms_timebase.sv]
// Free-running timebase that pulses once per 50 us
`timescale 1ns/1ns
`default_nettype none
module sub_ms_timebase #(
    parameter int TICK_CYCLES = 12500
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clock_enable,
    // Tick
    output logic tick
);
    logic [15:0] count_q;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= 16'h0000;
            tick <= 1'b0;
        end else if (clock_enable) begin
            tick <= (count_q == 16'(TICK_CYCLES - 1));
            if (count_q == 16'(TICK_CYCLES - 1)) begin
                count_q <= 16'h0000;
            end else begin
                count_q <= count_q + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// [hdl/startup_timeout_supervisor.sv]
// Start-up and shut-down sequencer with start-up timeout supervision
// Function
// - Rise time 0 to 31.75 ms in 0.25 ms steps; below 0.5 ms acts as 0.5 ms.
// - Bad writes are rejected, flagged and reported.
// - Timeout runs from turn-on delay end until output reaches 85 percent.
// - Timeout limit programmable 0 to 127 ms in 0.5 ms steps.
// - At expiry, last sample below 87.5 percent of command is a fault.
// - Telemetry lag may flag a fault for dips up to 2 ms before expiry.
// - A zero timeout limit disables timeout detection.
// - Undervoltage detection is armed only when the rise time ends.
// - Timeout fault sets three status flags and notifies the host.
// - Action field: ignore, delayed or immediate shutdown; 11b invalid.
// - Retry field: 0 latches off, 1 to 6 retries, 7 retries forever.
// - Delay field sets shutdown delay in ms and restart wait in rises.
// - Turn-off delay runs from stop until energy delivery ends.
// - Timing words: exponent 15:11, mantissa 10:0, mantissas from NVM.
// - Turn-on delay 0 to 127.5 ms in 0.5 ms steps before the rise.
// - Rise time sets ramp slope so the ramp lasts the rise time.
// - Turn-off delay 0 to 127.5 ms in 0.25 ms steps less up to 50 us.
`include "startup_timeout_supervisor_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module startup_timeout_supervisor #(
    parameter int TICK_CYCLES = `TICK_TIME_NS / `CLOCK_PERIOD_NS
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clock_enable,
    // Command port
    input wire logic cmd_write,
    input wire logic cmd_read,
    input wire logic [7:0] cmd_code,
    input wire startup_timeout_supervisor_pkg::word_t cmd_wdata,
    output startup_timeout_supervisor_pkg::word_t read_data,
    output logic read_valid,
    // Non-volatile defaults
    input wire logic [10:0] nvm_rise_time_mantissa,
    input wire logic [10:0] nvm_timeout_limit_mantissa,
    input wire logic [7:0] nvm_timeout_response,
    input wire logic [10:0] nvm_on_delay_mantissa,
    input wire logic [10:0] nvm_off_delay_mantissa,
    // Converter side
    input wire logic run_request,
    input wire startup_timeout_supervisor_pkg::word_t vout_command,
    input wire startup_timeout_supervisor_pkg::word_t vout_sample,
    input wire logic vout_sample_valid,
    output logic power_stage_enable,
    output logic ramp_active,
    output startup_timeout_supervisor_pkg::word_t ramp_elapsed,
    output startup_timeout_supervisor_pkg::word_t ramp_span,
    output logic uv_detect_armed,
    // Status and notification
    input wire logic clear_faults,
    output logic status_invalid_data,
    output logic status_none_above,
    output logic status_word_vout,
    output logic status_vout_timeout,
    output logic host_alert_n,
    output logic fault_event
);
    import startup_timeout_supervisor_pkg::*;

    // Word to {valid, quarters}; only exponents -2 and -1 are legal
    function automatic logic [13:0] to_quarters(input word_t w);
        logic [4:0] e;
        logic [10:0] m;
        e = w[`EXP_MSB:`EXP_LSB];
        m = w[`MAN_MSB:0];
        if (m[`MAN_MSB]) begin
            to_quarters = 14'h0000;
        end else if (e == `EXP_QUARTER_MS) begin
            to_quarters = {1'b1, 2'b00, m};
        end else if (e == `EXP_HALF_MS) begin
            to_quarters = {1'b1, 1'b0, m, 1'b0};
        end else begin
            to_quarters = 14'h0000;
        end
    endfunction

    function automatic word_t to_sub(input quarters_t q);
        to_sub = 16'({3'b000, q} * `SUB_PER_QUARTER);
    endfunction

    logic tick;
    sub_ms_timebase #(.TICK_CYCLES(TICK_CYCLES)) u_timebase (
        .clock(clock),
        .reset_n(reset_n),
        .clock_enable(clock_enable),
        .tick(tick)
    );

    // Register file
    quarters_t rise_q, limit_q, on_delay_q, off_delay_q;
    logic [7:0] response_q;
    logic loaded_q;
    logic invalid_write;
    logic [13:0] wq;
    logic [1:0] w_action;
    always_comb begin
        wq = to_quarters(cmd_wdata);
        w_action = cmd_wdata[`ACTION_MSB:`ACTION_LSB];
        invalid_write = 1'b0;
        if (cmd_write) begin
            case (cmd_code)
                `CMD_SOFT_START_RISE_TIME: invalid_write = !wq[13] || wq[12:0] > `RISE_MAX_Q;
                `CMD_STARTUP_TIMEOUT_LIMIT: invalid_write = !wq[13] || wq[0]
                    || wq[12:0] > `LIMIT_MAX_Q;
                `CMD_STARTUP_TIMEOUT_RESPONSE: invalid_write = (cmd_wdata[15:8] != 8'h00)
                    || (w_action == 2'h3);
                `CMD_TURN_ON_DELAY: invalid_write = !wq[13] || wq[0]
                    || wq[12:0] > `ON_DELAY_MAX_Q;
                `CMD_TURN_OFF_DELAY_TIME: invalid_write = !wq[13]
                    || wq[12:0] > `OFF_DELAY_MAX_Q;
                default: invalid_write = 1'b1;
            endcase
        end
    end

    // Defaults are caught from NVM on the first enabled cycle after reset release
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            loaded_q <= 1'b0;
            rise_q <= 13'h0000;
            limit_q <= 13'h0000;
            response_q <= 8'h00;
            on_delay_q <= 13'h0000;
            off_delay_q <= 13'h0000;
        end else if (clock_enable) begin
            if (!loaded_q) begin
                loaded_q <= 1'b1;
                rise_q <= {2'b00, nvm_rise_time_mantissa};
                limit_q <= {1'b0, nvm_timeout_limit_mantissa, 1'b0};
                response_q <= nvm_timeout_response;
                on_delay_q <= {1'b0, nvm_on_delay_mantissa, 1'b0};
                off_delay_q <= {1'b0, nvm_off_delay_mantissa, 1'b0};
            end else if (cmd_write && !invalid_write) begin
                case (cmd_code)
                    `CMD_SOFT_START_RISE_TIME: rise_q <= wq[12:0];
                    `CMD_STARTUP_TIMEOUT_LIMIT: limit_q <= wq[12:0];
                    `CMD_STARTUP_TIMEOUT_RESPONSE: response_q <= cmd_wdata[7:0];
                    `CMD_TURN_ON_DELAY: on_delay_q <= wq[12:0];
                    `CMD_TURN_OFF_DELAY_TIME: off_delay_q <= wq[12:0];
                    default: ;
                endcase
            end
        end
    end

    // Reads answer one cycle later in the native exponent of each word
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            read_data <= 16'h0000;
            read_valid <= 1'b0;
        end else if (clock_enable) begin
            read_valid <= cmd_read;
            if (cmd_read) begin
                case (cmd_code)
                    `CMD_SOFT_START_RISE_TIME: read_data <= {`EXP_QUARTER_MS, rise_q[10:0]};
                    `CMD_STARTUP_TIMEOUT_LIMIT: read_data <= {`EXP_HALF_MS, limit_q[11:1]};
                    `CMD_STARTUP_TIMEOUT_RESPONSE: read_data <= {8'h00, response_q};
                    `CMD_TURN_ON_DELAY: read_data <= {`EXP_HALF_MS, on_delay_q[11:1]};
                    `CMD_TURN_OFF_DELAY_TIME: read_data <= {`EXP_QUARTER_MS, off_delay_q[10:0]};
                    default: read_data <= 16'h0000;
                endcase
            end
        end
    end

    // Effective intervals in 50 us units
    logic [2:0] delay_code, retry_code;
    logic [1:0] action;
    word_t rise_sub, limit_sub, on_sub, off_sub, delay_sub, wait_sub;
    logic [18:0] wait_prod;
    always_comb begin
        action = response_q[`ACTION_MSB:`ACTION_LSB];
        retry_code = response_q[`RETRY_MSB:`RETRY_LSB];
        delay_code = response_q[`DELAY_MSB:`DELAY_LSB];
        rise_sub = to_sub((rise_q < `RISE_MIN_Q) ? `RISE_MIN_Q : rise_q);
        limit_sub = to_sub(limit_q);
        on_sub = to_sub(on_delay_q);
        off_sub = to_sub(off_delay_q);
        delay_sub = 16'({13'h0000, delay_code} * `SUB_PER_MS);
        wait_prod = rise_sub * ((delay_code == 3'h0) ? 3'h1 : delay_code);
        wait_sub = wait_prod[15:0];
    end

    // Telemetry thresholds
    word_t last_sample_q;
    logic [23:0] good_prod;
    logic below_fault, reached_good;
    always_comb begin
        good_prod = vout_command * `GOOD_NUM;
        reached_good = last_sample_q >= good_prod[`GOOD_SHIFT +: 16];
        below_fault = last_sample_q < (vout_command - (vout_command >> `FAULT_SHIFT));
    end
    // Only the latest sample is kept, so a dip seen up to the telemetry lag before expiry counts
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            last_sample_q <= 16'h0000;
        end else if (clock_enable && vout_sample_valid) begin
            last_sample_q <= vout_sample;
        end
    end

    // Sequencer
    seq_state_e state_q, state_d;
    word_t timer_q, timeout_q;
    logic timeout_active_q, timeout_fault;
    logic [2:0] retries_left_q;
    logic out_of_retries;
    assign out_of_retries = (retry_code == `RETRY_LATCH)
        || (retry_code != `RETRY_FOREVER && retries_left_q == 3'h0);

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_OFF: if (run_request && loaded_q) state_d = ST_ON_DELAY;
            ST_ON_DELAY: begin
                if (!run_request) state_d = ST_OFF;
                else if (timer_q == 16'h0000) state_d = ST_RISE;
            end
            ST_RISE: begin
                if (!run_request) state_d = ST_OFF_DELAY;
                else if (timer_q == 16'h0000) state_d = ST_REGULATE;
            end
            ST_REGULATE: begin
                if (!run_request) state_d = ST_OFF_DELAY;
                else if (timeout_fault && action == `ACT_DELAYED) state_d = ST_FAULT_DELAY;
                else if (timeout_fault && action == `ACT_SHUTDOWN) begin
                    state_d = out_of_retries ? ST_LATCHED : ST_RESTART_WAIT;
                end
            end
            ST_FAULT_DELAY: begin
                if (!run_request) state_d = ST_OFF_DELAY;
                else if (timer_q == 16'h0000) begin
                    if (!below_fault) state_d = ST_REGULATE;
                    else state_d = out_of_retries ? ST_LATCHED : ST_RESTART_WAIT;
                end
            end
            ST_RESTART_WAIT: begin
                if (!run_request) state_d = ST_OFF;
                else if (timer_q == 16'h0000) state_d = ST_ON_DELAY;
            end
            ST_LATCHED: if (!run_request) state_d = ST_OFF;
            ST_OFF_DELAY: if (timer_q == 16'h0000) state_d = ST_OFF;
            default: state_d = ST_OFF;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_OFF;
            timer_q <= 16'h0000;
        end else if (clock_enable) begin
            state_q <= state_d;
            if (state_d != state_q) begin
                case (state_d)
                    ST_ON_DELAY: timer_q <= on_sub;
                    ST_RISE: timer_q <= rise_sub;
                    ST_FAULT_DELAY: timer_q <= delay_sub;
                    ST_RESTART_WAIT: timer_q <= wait_sub;
                    ST_OFF_DELAY: timer_q <= off_sub;
                    default: timer_q <= 16'h0000;
                endcase
            end else if (tick && timer_q != 16'h0000) begin
                timer_q <= timer_q - 16'h0001;
            end
        end
    end

    // Retries restart from the field on each fresh start and after a good start
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            retries_left_q <= 3'h0;
        end else if (clock_enable) begin
            if (state_q == ST_OFF || (timeout_active_q && reached_good)) begin
                retries_left_q <= retry_code;
            end else if (state_d == ST_RESTART_WAIT && state_q != ST_RESTART_WAIT
                && retry_code != `RETRY_FOREVER) begin
                retries_left_q <= retries_left_q - 3'h1;
            end
        end
    end

    // Timeout supervision from the end of the turn-on delay
    assign timeout_fault = timeout_active_q && timeout_q == 16'h0000 && below_fault;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            timeout_active_q <= 1'b0;
            timeout_q <= 16'h0000;
        end else if (clock_enable) begin
            if (state_q == ST_ON_DELAY && state_d == ST_RISE) begin
                timeout_active_q <= (limit_q != 13'h0000);
                timeout_q <= limit_sub;
            end else if (!power_stage_enable || reached_good || timeout_q == 16'h0000) begin
                timeout_active_q <= 1'b0;
            end else if (tick) begin
                timeout_q <= timeout_q - 16'h0001;
            end
        end
    end

    // Converter controls
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            power_stage_enable <= 1'b0;
            ramp_active <= 1'b0;
            ramp_elapsed <= 16'h0000;
            ramp_span <= 16'h0000;
            uv_detect_armed <= 1'b0;
        end else if (clock_enable) begin
            power_stage_enable <= (state_d == ST_RISE) || (state_d == ST_REGULATE)
                || (state_d == ST_FAULT_DELAY) || (state_d == ST_OFF_DELAY);
            ramp_active <= (state_d == ST_RISE);
            ramp_span <= rise_sub;
            if (state_d == ST_RISE && state_q != ST_RISE) ramp_elapsed <= 16'h0000;
            else if (state_q == ST_RISE && tick) ramp_elapsed <= ramp_elapsed + 16'h0001;
            if (state_q == ST_RISE && state_d == ST_REGULATE) uv_detect_armed <= 1'b1;
            else if (state_d != ST_REGULATE && state_d != ST_FAULT_DELAY) uv_detect_armed <= 1'b0;
        end
    end

    // Status flags: a new event in the clearing cycle keeps its flag
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            status_invalid_data <= 1'b0;
            status_none_above <= 1'b0;
            status_word_vout <= 1'b0;
            status_vout_timeout <= 1'b0;
            fault_event <= 1'b0;
            host_alert_n <= 1'b1;
        end else if (clock_enable) begin
            status_invalid_data <= invalid_write || (status_invalid_data && !clear_faults);
            status_none_above <= timeout_fault || (status_none_above && !clear_faults);
            status_word_vout <= timeout_fault || (status_word_vout && !clear_faults);
            status_vout_timeout <= timeout_fault || (status_vout_timeout && !clear_faults);
            fault_event <= timeout_fault || invalid_write;
            host_alert_n <= !(timeout_fault || invalid_write
                || ((status_invalid_data || status_vout_timeout) && !clear_faults));
        end
    end
endmodule
`default_nettype wire

// [verification/startup_timeout_supervisor_checker.sv]
// Port-level assertions for the start-up supervisor
`timescale 1ns/1ns
`default_nettype none
module startup_timeout_supervisor_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Command port
    input wire logic clock_enable,
    input wire logic cmd_read,
    input wire logic read_valid,
    // Sequencer
    input wire logic power_stage_enable,
    input wire logic ramp_active,
    input wire startup_timeout_supervisor_pkg::word_t ramp_elapsed,
    input wire startup_timeout_supervisor_pkg::word_t ramp_span,
    input wire logic uv_detect_armed,
    // Status
    input wire logic status_invalid_data,
    input wire logic status_none_above,
    input wire logic status_word_vout,
    input wire logic status_vout_timeout,
    input wire logic host_alert_n,
    input wire logic fault_event
);
    import startup_timeout_supervisor_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    property p_read_answer;
        cmd_read && clock_enable |=> read_valid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
    property p_bad_write;
        $rose(status_invalid_data) |-> fault_event && !host_alert_n;
    endproperty
    a_bad_write: assert property (p_bad_write) else $error("invalid data not reported");
    property p_alert_held;
        status_invalid_data || status_vout_timeout |-> !host_alert_n;
    endproperty
    a_alert_held: assert property (p_alert_held) else $error("alert released early");
    property p_timeout_flags;
        $rose(status_vout_timeout) |-> status_none_above && status_word_vout && fault_event;
    endproperty
    a_timeout_flags: assert property (p_timeout_flags) else $error("timeout flag set incomplete");
    property p_min_span;
        ramp_active |-> ramp_span >= 16'h000a;
    endproperty
    a_min_span: assert property (p_min_span) else $error("rise shorter than minimum");
    property p_rise_length;
        $rose(ramp_active) |-> ramp_active [*8];
    endproperty
    a_rise_length: assert property (p_rise_length) else $error("ramp ended too soon");
    property p_elapsed_bound;
        ramp_active |-> ramp_elapsed <= ramp_span;
    endproperty
    a_elapsed_bound: assert property (p_elapsed_bound) else $error("ramp overran its span");
    property p_uv_late;
        ramp_active |-> !uv_detect_armed;
    endproperty
    a_uv_late: assert property (p_uv_late) else $error("undervoltage armed during rise");
    property p_power_ramp;
        ramp_active |-> power_stage_enable;
    endproperty
    a_power_ramp: assert property (p_power_ramp) else $error("ramp without power stage");
    c_timeout: cover property ($rose(status_vout_timeout));
    c_invalid: cover property ($rose(status_invalid_data));
    c_ramp_done: cover property ($fell(ramp_active) && uv_detect_armed);
endmodule
bind startup_timeout_supervisor startup_timeout_supervisor_checker chk (.*);
`default_nettype wire

// [verification/vout_telemetry_model.sv]
// Converter output and lagging telemetry seen by the supervisor
`timescale 1ns/1ns
`default_nettype none
module vout_telemetry_model (
    // Clock
    input wire logic clock,
    // From supervisor
    input wire logic power_stage_enable,
    input wire logic ramp_active,
    input wire startup_timeout_supervisor_pkg::word_t ramp_elapsed,
    input wire startup_timeout_supervisor_pkg::word_t ramp_span,
    input wire startup_timeout_supervisor_pkg::word_t vout_command,
    // Scenario control
    input wire logic stalled,
    // Telemetry
    output startup_timeout_supervisor_pkg::word_t vout_sample,
    output logic vout_sample_valid
);
    import startup_timeout_supervisor_pkg::*;
    logic [2:0] div_q = 3'h0;
    // Samples only every eighth cycle, so the supervisor always sees stale data
    always_ff @(posedge clock) begin
        div_q <= div_q + 3'h1;
        vout_sample_valid <= (div_q == 3'h7);
        if (!power_stage_enable)
            vout_sample <= 16'h0000;
        else if (stalled)
            vout_sample <= vout_command >> 2;
        else if (ramp_active && ramp_span != 16'h0000)
            vout_sample <= 16'((32'(vout_command) * 32'(ramp_elapsed)) / 32'(ramp_span));
        else
            vout_sample <= vout_command;
    end
endmodule
`default_nettype wire

// [verification/startup_timeout_supervisor_bench.sv]
// Self-checking bench for the start-up supervisor
`timescale 1ns/1ns
`default_nettype none
module startup_timeout_supervisor_bench;
    import startup_timeout_supervisor_pkg::*;
    localparam logic [7:0] codes [12] = '{8'h61, 8'h61, 8'h61, 8'h61, 8'h61, 8'h61,
        8'h62, 8'h62, 8'h63, 8'h64, 8'h60, 8'h72};
    localparam word_t datas [12] = '{16'hf014, 16'hf80a, 16'hf07f, 16'hf080, 16'h0014,
        16'hf7ff, 16'hf8fe, 16'hf0ff, 16'h00c0, 16'hf1fe, 16'hf0ff, 16'h0000};
    localparam word_t backs [12] = '{16'hf014, 16'hf014, 16'hf07f, 16'hf07f, 16'hf07f,
        16'hf07f, 16'hf8fe, 16'hf8fe, 16'h0080, 16'hf1fe, 16'hf801, 16'h0000};
    localparam logic [11:0] goods = 12'h247;
    localparam logic [7:0] resps [3] = '{8'h00, 8'h80, 8'h49};
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic clock_enable = 1'b1;
    logic cmd_write = 1'b0;
    logic cmd_read = 1'b0;
    logic [7:0] cmd_code = 8'h00;
    word_t cmd_wdata = 16'h0000;
    logic run_request = 1'b0;
    logic clear_faults = 1'b0;
    logic stalled = 1'b0;
    word_t vout_command = 16'h0c80;
    logic [7:0] nvm_timeout_response = 8'h80;
    word_t read_data, vout_sample, ramp_elapsed, ramp_span;
    logic read_valid, vout_sample_valid, power_stage_enable, ramp_active, uv_detect_armed;
    logic status_invalid_data, status_none_above, status_word_vout, status_vout_timeout;
    logic host_alert_n, fault_event;
    word_t exp_q [$];
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    int faults = 0;
    int f0, n;
    logic [31:0] rnd = 32'h72e9;
    // Shorter timebase keeps every interval at four cycles per 50 us tick
    startup_timeout_supervisor #(.TICK_CYCLES(4)) dut (.*, .nvm_rise_time_mantissa(11'h004),
        .nvm_timeout_limit_mantissa(11'h006), .nvm_on_delay_mantissa(11'h001),
        .nvm_off_delay_mantissa(11'h002));
    vout_telemetry_model partner (.*);
    initial begin
        forever #2 clock = ~clock;
    end
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic word_t flags();
        return {10'h000, status_invalid_data, status_none_above, status_word_vout,
            status_vout_timeout, fault_event, host_alert_n};
    endfunction
    task automatic stop_test();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input word_t seen, input word_t expd);
        checked = checked + 1;
        if (seen !== expd) begin
            failures = failures + 1;
            $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, expd);
        end
    endtask
    task automatic wr(input logic [7:0] code, input word_t data);
        @(posedge clock);
        cmd_write <= 1'b1;
        cmd_code <= code;
        cmd_wdata <= data;
        @(posedge clock);
        cmd_write <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] code, input word_t expd);
        exp_q.push_back(expd);
        @(posedge clock);
        cmd_read <= 1'b1;
        cmd_code <= code;
        @(posedge clock);
        cmd_read <= 1'b0;
    endtask
    task automatic clear();
        @(posedge clock);
        clear_faults <= 1'b1;
        @(posedge clock);
        clear_faults <= 1'b0;
        #1;
    endtask
    task automatic start(input logic hold);
        @(posedge clock);
        stalled <= hold;
        run_request <= 1'b1;
        f0 = faults;
        for (n = 0; n < 1000 && fault_event !== 1'b1; n++) @(negedge clock);
    endtask
    task automatic stop();
        @(posedge clock);
        run_request <= 1'b0;
        stalled <= 1'b0;
        repeat (200) @(posedge clock);
        clear();
    endtask
    // Answers are matched in request order; a stray answer is a failure
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (fault_event === 1'b1) faults <= faults + 1;
        if (read_valid === 1'b1 && exp_q.size() == 0) check(16'h0001, 16'h0000);
        else if (read_valid === 1'b1) check(read_data, exp_q.pop_front());
        if (cycles == 40000) begin
            failures = failures + 1;
            stop_test();
        end
    end
    initial begin
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
        rd(8'h60, 16'hf801);
        rd(8'h61, 16'hf004);
        rd(8'h62, 16'hf806);
        rd(8'h63, 16'h0080);
        rd(8'h64, 16'hf004);
        @(posedge clock);
        clock_enable <= 1'b0;
        cmd_read <= 1'b1;
        @(posedge clock);
        clock_enable <= 1'b1;
        cmd_read <= 1'b0;
        for (int i = 0; i < 12; i++) begin
            wr(codes[i], datas[i]);
            check(flags(), goods[i] ? 16'h0001 : 16'h0022);
            clear();
            rd(codes[i], backs[i]);
        end
        for (int k = 0; k < 4; k++) begin
            rnd = xorshift(rnd);
            wr(8'h61, {9'h1e0, rnd[6:0]});
            rd(8'h61, {9'h1e0, rnd[6:0]});
        end
        wr(8'h61, 16'hf000);
        wr(8'h62, 16'hf806);
        wr(8'h64, 16'hf004);
        @(posedge clock);
        run_request <= 1'b1;
        for (n = 0; n < 500 && ramp_active !== 1'b1; n++) @(negedge clock);
        check(16'(n > 37 && n < 51), 16'h0001);
        check(ramp_span, 16'h000a);
        for (n = 0; n < 500 && ramp_active === 1'b1; n++) @(negedge clock);
        check(16'(n > 35 && n < 47), 16'h0001);
        check({14'h0, uv_detect_armed, power_stage_enable}, 16'h0003);
        f0 = faults;
        repeat (400) @(negedge clock);
        check(16'(faults - f0), 16'h0000);
        @(posedge clock);
        run_request <= 1'b0;
        for (n = 0; n < 500 && power_stage_enable === 1'b1; n++) @(negedge clock);
        check(16'(n > 77 && n < 93), 16'h0001);
        repeat (20) @(posedge clock);
        wr(8'h62, 16'hf800);
        start(1'b1);
        check({15'h0, power_stage_enable}, 16'h0001);
        check(16'(faults - f0), 16'h0000);
        stop();
        wr(8'h62, 16'hf806);
        for (int k = 0; k < 3; k++) begin
            wr(8'h63, resps[k]);
            start(1'b1);
            check(16'(n > 272 && n < 300), 16'h0001);
            check(flags(), 16'h001e);
            repeat (60) @(negedge clock);
            check({15'h0, power_stage_enable}, {15'h0, resps[k] != 8'h80});
            if (resps[k] == 8'h49) begin
                for (n = 0; n < 100 && power_stage_enable === 1'b1; n++) @(negedge clock);
                check(16'(n > 11 && n < 30), 16'h0001);
                for (n = 0; n < 1000 && fault_event !== 1'b1; n++) @(negedge clock);
                check(16'(n < 1000), 16'h0001);
            end
            repeat (400) @(negedge clock);
            check({15'h0, power_stage_enable}, {15'h0, resps[k] == 8'h00});
            stop();
        end
        stop_test();
    end
endmodule
`default_nettype wire
